// ### core/seconds_consts.svh
// Register map, field positions, reset values and timing counts of the seconds counter.
// Assumes byte addresses on an 8-bit register address port with 32-bit data.
`ifndef SECONDS_CONSTS_SVH
`define SECONDS_CONSTS_SVH

`define SC_MODE_OFS     8'h00
`define SC_ALARM_OFS    8'h04
`define SC_COUNT_OFS    8'h08
`define SC_FLAGS_OFS    8'h0c
`define SC_IRQCLR_OFS   8'h10

`define SC_PRESC_MSB    15
`define SC_ALARM_IRQ_ENABLE_BIT   16
`define SC_INCIEN_BIT   17
`define SC_RESTART_BIT  18
`define SC_ALMF_BIT     0
`define SC_INCF_BIT     1

`define SC_PRESC_RST    16'h8000
`define SC_ALARM_RST    32'hffff_ffff
`define SC_COUNT_RST    32'h0000_0000

// Slow clock edges between a restart or flag-clear request and its effect.
`define SC_SLOW_DELAY   2'h2

`endif

// ### core/seconds_counter_unit.sv
// Top of the seconds counter: register port, slow clock sampling, delayed
// restart and flag clear, alarm compare, event flags and interrupt.
// Assumes slow_tick_source is a free running slow clock from another domain
// and a register master that never issues read and write strobes together.
`timescale 1ns/1ns
`default_nettype none
`include "seconds_consts.svh"

module seconds_counter_unit (
    input  wire logic        clk_sys,          // System bus clock, 20 MHz.
    input  wire logic        arst_n,           // Asynchronous reset, active low.
    input  wire logic [7:0]  reg_addr,         // Register byte address.
    input  wire logic [31:0] reg_wdata,        // Write data.
    input  wire logic        reg_wr,           // Write strobe, one cycle.
    input  wire logic        reg_rd,           // Read strobe, one cycle.
    output logic      [31:0] reg_rdata,        // Read data, cycle after reg_rd.
    input  wire logic        slow_tick_source, // Slow clock pin.
    output logic             irq               // Level interrupt, active high.
);

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock sampling.

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic slow_tick;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= slow_tick_source;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign slow_tick = sync2_r && !sync3_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [15:0]          presc_r;
    logic                 alarm_irq_enable_r;
    logic                 incien_r;
    seconds_pkg::word_t   alarm_r;
    seconds_pkg::flags_t  flags_r;
    logic [31:0]          rdata_r;
    logic                 irq_r;

    logic mode_wr;
    logic alarm_wr;
    logic clr_wr;
    logic flags_rd;

    assign mode_wr  = reg_wr && reg_addr == `SC_MODE_OFS;
    assign alarm_wr = reg_wr && reg_addr == `SC_ALARM_OFS;
    assign clr_wr   = reg_wr && reg_addr == `SC_IRQCLR_OFS;
    assign flags_rd = reg_rd && reg_addr == `SC_FLAGS_OFS;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            presc_r  <= `SC_PRESC_RST;
            alarm_irq_enable_r <= 1'b0;
            incien_r <= 1'b0;
        end else if (mode_wr) begin
            presc_r  <= reg_wdata[`SC_PRESC_MSB:0];
            alarm_irq_enable_r <= reg_wdata[`SC_ALARM_IRQ_ENABLE_BIT];
            incien_r <= reg_wdata[`SC_INCIEN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alarm_r <= `SC_ALARM_RST;
        end else if (alarm_wr) begin
            alarm_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delayed requests. The slow side only sees a request on its own edges,
    // so both restart and flag clear wait for the second slow edge after the
    // bus access. A repeat request merges with a pending one, or arms a new wait if it lands in the cycle the pending one fires.

    function automatic logic fire_of(input logic pend, input logic tick, input logic [1:0] cnt);
        fire_of = pend && tick && cnt == (`SC_SLOW_DELAY - 2'h1);
    endfunction : fire_of

    logic       rst_pend_r;
    logic [1:0] rst_cnt_r;
    logic       rst_fire;
    logic       clr_pend_r;
    logic [1:0] clr_cnt_r;
    logic       clr_fire;

    assign rst_fire = fire_of(rst_pend_r, slow_tick, rst_cnt_r);
    assign clr_fire = fire_of(clr_pend_r, slow_tick, clr_cnt_r);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_pend_r <= 1'b0;
            rst_cnt_r  <= 2'h0;
        end else if (rst_fire) begin
            rst_pend_r <= mode_wr && reg_wdata[`SC_RESTART_BIT];
            rst_cnt_r  <= 2'h0;
        end else if (rst_pend_r && slow_tick) begin
            rst_cnt_r  <= rst_cnt_r + 2'h1;
        end else if (mode_wr && reg_wdata[`SC_RESTART_BIT] && !rst_pend_r) begin
            rst_pend_r <= 1'b1;
            rst_cnt_r  <= 2'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clr_pend_r <= 1'b0;
            clr_cnt_r  <= 2'h0;
        end else if (clr_fire) begin
            clr_pend_r <= flags_rd;
            clr_cnt_r  <= 2'h0;
        end else if (clr_pend_r && slow_tick) begin
            clr_cnt_r  <= clr_cnt_r + 2'h1;
        end else if (flags_rd && !clr_pend_r) begin
            clr_pend_r <= 1'b1;
            clr_cnt_r  <= 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider and counter.

    tick_if tk ();

    assign tk.slow_tick = slow_tick;
    assign tk.restart   = rst_fire;
    assign tk.presc     = presc_r;

    seconds_divider u_divider (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .tb      (tk.core)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event flags. A new event wins over a clear landing in the same cycle.

    logic alarm_hit;

    assign alarm_hit = tk.inc && tk.count == alarm_r + 32'h0000_0001;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flags_r.inc   <= 1'b0;
            flags_r.alarm <= 1'b0;
        end else begin
            if (tk.inc) begin
                flags_r.inc <= 1'b1;
            end else if (clr_fire || (clr_wr && reg_wdata[`SC_INCF_BIT])) begin
                flags_r.inc <= 1'b0;
            end
            if (alarm_hit) begin
                flags_r.alarm <= 1'b1;
            end else if (clr_fire || (clr_wr && reg_wdata[`SC_ALMF_BIT])) begin
                flags_r.alarm <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (flags_r.alarm && alarm_irq_enable_r) || (flags_r.inc && incien_r);
        end
    end

    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Read port. Data stand only in the cycle after the strobe; the restart
    // bit is a trigger and always reads as zero.

    function automatic logic [31:0] read_of(input logic [7:0] addr);
        unique case (addr)
            `SC_MODE_OFS:  read_of = {13'h0000, 1'b0, incien_r, alarm_irq_enable_r, presc_r};
            `SC_ALARM_OFS: read_of = alarm_r;
            `SC_COUNT_OFS: read_of = tk.count;
            `SC_FLAGS_OFS: read_of = {30'h0000_0000, flags_r.inc, flags_r.alarm};
            default:       read_of = 32'h0000_0000;
        endcase
    endfunction : read_of

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= reg_rd ? read_of(reg_addr) : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_alarm_sets_flag: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (tk.inc && tk.count == alarm_r + 32'h0000_0001) |=> flags_r.alarm)
        else $error("alarm match did not set the alarm flag");

    chk_alarm_needs_match: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(flags_r.alarm) |-> $past(tk.inc && tk.count == alarm_r + 32'h0000_0001))
        else $error("alarm flag rose without a count match");

    chk_inc_sets_flag: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        tk.inc |=> flags_r.inc)
        else $error("count advance did not set the increment flag");

    chk_clear_waits: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        ($fell(flags_r.inc) && !$past(clr_wr)) |-> $past(clr_pend_r && slow_tick && clr_cnt_r == 2'h1))
        else $error("increment flag cleared before the second slow edge");

    chk_read_clears: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (clr_fire && !tk.inc && !alarm_hit) |=> (!flags_r.inc && !flags_r.alarm))
        else $error("status read did not clear the flags");

    chk_restart_delay: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rst_fire |-> ($past(rst_pend_r) && rst_cnt_r == 2'h1) ##1 tk.count == 32'h0000_0000)
        else $error("restart fired at the wrong time or left a count");

    chk_irq_alarm: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (flags_r.alarm && alarm_irq_enable_r) |=> irq)
        else $error("enabled alarm flag did not raise the interrupt");

    chk_irq_inc: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (flags_r.inc && incien_r) |=> irq)
        else $error("enabled increment flag did not raise the interrupt");

    chk_irq_cause: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        irq |-> $past((flags_r.alarm && alarm_irq_enable_r) || (flags_r.inc && incien_r)))
        else $error("interrupt high without an enabled flag");

    chk_status_layout: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        flags_rd |=> reg_rdata == {30'h0000_0000, $past(flags_r.inc), $past(flags_r.alarm)})
        else $error("status read data has the wrong layout");

    chk_restart_arms: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (mode_wr && reg_wdata[`SC_RESTART_BIT] && !rst_pend_r)
            |=> (rst_pend_r && rst_cnt_r == 2'h0))
        else $error("restart write did not arm a delayed restart");

    chk_restart_kept: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (rst_pend_r && !rst_fire) |=> rst_pend_r)
        else $error("pending restart was dropped before it fired");

    chk_restart_ticks: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (rst_pend_r && !slow_tick) |=> $stable(rst_cnt_r))
        else $error("restart wait moved without a slow tick");

    chk_clear_arms: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (flags_rd && !clr_pend_r)
            |=> (clr_pend_r && clr_cnt_r == 2'h0))
        else $error("status read did not arm a delayed clear");

    chk_clear_kept: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (clr_pend_r && !clr_fire) |=> clr_pend_r)
        else $error("pending clear was dropped before it fired");

    chk_clear_ticks: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (clr_pend_r && !slow_tick) |=> $stable(clr_cnt_r))
        else $error("clear wait moved without a slow tick");

    chk_alarm_sticky: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (flags_r.alarm && !clr_fire && !(clr_wr && reg_wdata[`SC_ALMF_BIT])) |=> flags_r.alarm)
        else $error("alarm flag dropped without a clear");

    chk_inc_sticky: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (flags_r.inc && !clr_fire && !(clr_wr && reg_wdata[`SC_INCF_BIT])) |=> flags_r.inc)
        else $error("increment flag dropped without a clear");

    chk_inc_needs_step: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(flags_r.inc) |-> $past(tk.inc))
        else $error("increment flag rose without a count advance");

    chk_irq_masked: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (!alarm_irq_enable_r && !incien_r) |=> !irq)
        else $error("interrupt high with both enables off");

    chk_restart_reads_zero: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (reg_rd && reg_addr == `SC_MODE_OFS) |=> !reg_rdata[`SC_RESTART_BIT])
        else $error("restart bit did not read as zero");

    chk_enable_bits: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        mode_wr |=> (alarm_irq_enable_r == $past(reg_wdata[`SC_ALARM_IRQ_ENABLE_BIT])
            && incien_r == $past(reg_wdata[`SC_INCIEN_BIT])))
        else $error("mode write did not load the enable bits");

    chk_count_only_steps: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $changed(tk.count) |-> (tk.inc || $past(rst_fire)))
        else $error("count changed without an advance or restart");

endmodule : seconds_counter_unit

`default_nettype wire

// ### core/seconds_divider.sv
// Prescaler and 32-bit elapsed counter, stepped by slow clock ticks.
// Assumes slow_tick is already synchronised into clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "seconds_consts.svh"

module seconds_divider (
    input  wire logic clk_sys,  // System clock.
    input  wire logic arst_n,   // Asynchronous reset, active low.
    tick_if.core      tb        // Tick, restart and count bundle.
);

    logic [15:0]        div_r;
    seconds_pkg::word_t count_r;
    logic               inc_r;

    // A down counter loaded with presc-1 gives a period of presc ticks;
    // a zero prescale wraps to 16'hffff and so gives 2^16 ticks.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_r   <= `SC_PRESC_RST - 16'h0001;
            count_r <= `SC_COUNT_RST;
            inc_r   <= 1'b0;
        end else if (tb.restart) begin
            div_r   <= tb.presc - 16'h0001;
            count_r <= `SC_COUNT_RST;
            inc_r   <= 1'b0;
        end else if (tb.slow_tick && div_r == 16'h0000) begin
            div_r   <= tb.presc - 16'h0001;
            count_r <= count_r + 32'h0000_0001;
            inc_r   <= 1'b1;
        end else begin
            if (tb.slow_tick) begin
                div_r <= div_r - 16'h0001;
            end
            inc_r <= 1'b0;
        end
    end

    assign tb.inc   = inc_r;
    assign tb.count = count_r;

    ////////////////////////////////////////////////////////////////////////////
    chk_count_step: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (tb.slow_tick && div_r == 16'h0000 && !tb.restart)
            |=> (inc_r && count_r == $past(count_r) + 32'h0000_0001))
        else $error("count did not step by one at prescaler expiry");

    chk_period_reload: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (tb.slow_tick && div_r == 16'h0000 && !tb.restart)
            |=> div_r == $past(tb.presc) - 16'h0001)
        else $error("prescaler not reloaded with presc minus one");

    chk_count_wrap: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (tb.slow_tick && div_r == 16'h0000 && !tb.restart && count_r == 32'hffff_ffff)
            |=> (count_r == 32'h0000_0000 && inc_r))
        else $error("count did not wrap to zero");

endmodule : seconds_divider

`default_nettype wire

// ### core/seconds_pkg.sv
// Shared types of the seconds counter.
// Assumes nothing of its surroundings.
package seconds_pkg;

    typedef logic [31:0] word_t;

    typedef struct packed {
        logic inc;
        logic alarm;
    } flags_t;

endpackage : seconds_pkg

// ### core/tick_if.sv
// Bundle between the register side and the divider/counter core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
`default_nettype none

interface tick_if;
    logic        slow_tick;  // One-cycle pulse per slow clock rising edge.
    logic        restart;    // One-cycle pulse, reload divider and zero count.
    logic [15:0] presc;      // Programmed prescale value.
    logic        inc;        // One-cycle pulse, count has just advanced.
    seconds_pkg::word_t count; // Current count.

    modport core (input slow_tick, input restart, input presc, output inc, output count);
    modport ctrl (output slow_tick, output restart, output presc, input inc, input count);
endinterface : tick_if

`default_nettype wire

// ### tb/seconds_counter_unit_bench.sv
// Self-checking bench of the seconds counter: register port, slow clock, flags and interrupt.
// Assumes the design core files and seconds_consts.svh are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "seconds_consts.svh"

module seconds_counter_unit_bench;
    logic        clk_sys;
    logic        arst_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        slow_tick_source;
    logic        irq;
    int          failures;
    int          n_tests;
    logic [31:0] seed;
    logic [31:0] c0;
    logic [31:0] c1;
    logic [15:0] p;
    logic        i0;

    seconds_counter_unit seconds_counter_unit_i (
        .clk_sys          (clk_sys),
        .arst_n           (arst_n),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .slow_tick_source (slow_tick_source),
        .irq              (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Slow clock of eight system cycles, so each level lasts well over two sync stages.
    always begin
        repeat (4) @(posedge clk_sys);
        slow_tick_source <= ~slow_tick_source;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic logic [31:0] mode_word(input logic [15:0] pv, input logic alm,
                                              input logic inc, input logic rst);
        return {13'h0000, rst, inc, alm, pv};
    endfunction : mode_word

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic periods(input int n);
        repeat (n * 8) @(posedge clk_sys);
        #1;
    endtask : periods

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_irq(input logic exp);
        n_tests++;
        if (irq !== exp) begin
            failures++;
            $display("mismatch at %0t: irq %b expected %b", $time, irq, exp);
        end
    endtask : chk_irq

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk_word(d, exp);
    endtask : rd_chk

    // The count moves on its own, so it is read until two reads agree.
    task automatic rd_count(output logic [31:0] d);
        logic [31:0] prev;
        rd(`SC_COUNT_OFS, d);
        for (int k = 0; k < 4; k++) begin
            prev = d;
            rd(`SC_COUNT_OFS, d);
            if (d === prev)
                break;
        end
    endtask : rd_count

    task automatic wrap_up;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////////////
    // The whole run needs about 10000 cycles; the limit leaves ample margin.
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        arst_n           = 1'b0;
        reg_addr         = 8'h00;
        reg_wdata        = 32'h0000_0000;
        reg_wr           = 1'b0;
        reg_rd           = 1'b0;
        slow_tick_source = 1'b0;
        failures         = 0;
        n_tests          = 0;
        seed             = 32'h9986d3bf;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        chk_irq(1'b0);
        rd_chk(`SC_MODE_OFS, mode_word(16'h8000, 1'b0, 1'b0, 1'b0));
        rd_chk(`SC_ALARM_OFS, 32'hffff_ffff);
        rd_chk(`SC_COUNT_OFS, 32'h0000_0000);
        rd_chk(`SC_FLAGS_OFS, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0000);
        rd_chk(`SC_IRQCLR_OFS, 32'h0000_0000);
        wr(`SC_COUNT_OFS, 32'h1234_5678);
        rd_chk(`SC_COUNT_OFS, 32'h0000_0000);
        wr(`SC_ALARM_OFS, 32'ha5a5_0f0f);
        rd_chk(`SC_ALARM_OFS, 32'ha5a5_0f0f);
        wr(`SC_ALARM_OFS, 32'hffff_ffff);

        // Random prescale values: three counts over exactly three prescaler periods.
        repeat (4) begin
            seed = xorshift(seed);
            p    = 16'(seed % 6) + 16'h0001;
            wr(`SC_MODE_OFS, mode_word(p, 1'b0, 1'b0, 1'b1));
            periods(4);
            rd(`SC_COUNT_OFS, c0);
            repeat (24 * int'(p) - 2) @(posedge clk_sys);
            rd(`SC_COUNT_OFS, c1);
            chk_word(c1 - c0, 32'h0000_0003);
        end
        rd_chk(`SC_MODE_OFS, mode_word(p, 1'b0, 1'b0, 1'b0));

        // Restart clears the count only after two slow cycles.
        wr(`SC_MODE_OFS, mode_word(16'h0006, 1'b0, 1'b0, 1'b1));
        rd(`SC_COUNT_OFS, c0);
        chk_word({31'h0, (c0 != 32'h0)}, 32'h0000_0001);
        periods(3);
        rd_chk(`SC_COUNT_OFS, 32'h0000_0000);

        // A zero prescale means a period of 65536 slow cycles: no count in 1000.
        wr(`SC_MODE_OFS, mode_word(16'h0000, 1'b0, 1'b0, 1'b1));
        periods(4);
        periods(1000);
        rd_chk(`SC_COUNT_OFS, 32'h0000_0000);

        // Increment flag, interrupt and the delayed clear on a status read.
        wr(`SC_MODE_OFS, mode_word(16'd100, 1'b0, 1'b1, 1'b1));
        periods(4);
        wr(`SC_IRQCLR_OFS, 32'h0000_0003);
        rd_chk(`SC_FLAGS_OFS, 32'h0000_0000);
        chk_irq(1'b0);
        periods(100);
        chk_irq(1'b1);
        rd_count(c0);
        chk_word(c0, 32'h0000_0001);
        rd_chk(`SC_FLAGS_OFS, 32'h0000_0002);
        rd_chk(`SC_FLAGS_OFS, 32'h0000_0002);
        chk_irq(1'b1);
        periods(3);
        chk_irq(1'b0);
        rd_chk(`SC_FLAGS_OFS, 32'h0000_0000);

        // Alarm at programmed value plus one, gated by its enable only.
        wr(`SC_ALARM_OFS, 32'h0000_0002);
        wr(`SC_MODE_OFS, mode_word(16'h0003, 1'b1, 1'b0, 1'b1));
        periods(3);
        wr(`SC_IRQCLR_OFS, 32'h0000_0003);
        c1 = 32'h0;
        for (int k = 0; k < 60 && c1 < 32'h4; k++) begin
            i0 = irq;
            rd(`SC_COUNT_OFS, c1);
            if (c1 < 32'h3)
                chk_word({31'h0, i0}, 32'h0000_0000);
        end
        chk_irq(1'b1);
        wr(`SC_MODE_OFS, mode_word(16'h0003, 1'b0, 1'b0, 1'b0));
        periods(1);
        chk_irq(1'b0);
        rd_chk(`SC_FLAGS_OFS, 32'h0000_0003);
        periods(3);
        rd(`SC_FLAGS_OFS, c0);
        chk_word(c0 & 32'h0000_0001, 32'h0000_0000);
        wr(`SC_MODE_OFS, mode_word(16'h0003, 1'b1, 1'b0, 1'b0));
        periods(1);
        chk_irq(1'b0);
        wrap_up();
    end
endmodule : seconds_counter_unit_bench

`default_nettype wire
